/* core/rbc_pkg.sv */
package rbc_pkg;

  // ==========================================================
  // Register map: word indices, byte address is four times the index.
  localparam logic [7:0] IDX_BIT_CTRL = 8'h0C;
  localparam logic [7:0] IDX_COLL_POS = 8'h0D;
  localparam logic [7:0] IDX_ERR      = 8'h20;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h22;

  // ==========================================================
  // Field positions.
  localparam int unsigned BC_KEEP_BIT   = 7;
  localparam int unsigned BC_ALIGN_LSB  = 4;
  localparam int unsigned BC_COLLISION_AS_INTEGRITY_ERROR_BIT = 3;
  localparam int unsigned BC_LAST_LSB   = 0;
  localparam int unsigned CP_VALID_BIT  = 7;
  localparam int unsigned EV_INTEG      = 0;
  localparam int unsigned EV_COLL       = 1;
  localparam int unsigned EV_DONE       = 2;
  localparam int unsigned EV_W          = 3;

  // ==========================================================
  // Reset values and limits.
  localparam logic [7:0]      BIT_CTRL_RST = 8'h00;
  localparam logic [7:0]      COLL_POS_RST = 8'h00;
  localparam logic [EV_W-1:0] EV_RST       = 3'h0;
  localparam logic [7:0]      COLL_LIMIT   = 8'h40;
  localparam logic [7:0]      IDX_SAT      = 8'hFF;

  // ==========================================================
  // Bus encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic {
    RBC_IDLE,
    RBC_RECV
  } rbc_rx_state_t;

endpackage

/* core/rbc_bit_packer.sv */
`timescale 1ns/1ps
module rbc_bit_packer (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       start,
  input  wire logic       finish,
  input  wire logic [2:0] align,
  // Bit stream
  input  wire logic       bit_valid,
  input  wire logic       bit_data,
  // Byte stream and tail count
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic [2:0]      tail_bits
);

  logic [2:0] pos_reg,   pos_next;
  logic [7:0] acc_reg,   acc_next;
  logic       bv_reg,    bv_next;
  logic [7:0] bd_reg,    bd_next;

  // ==========================================================
  // Packing.
  always_comb begin
    pos_next = pos_reg;
    acc_next = acc_reg;
    bv_next  = 1'b0;
    bd_next  = bd_reg;
    if (start) begin
      pos_next = align;
      acc_next = 8'h00;
    end else if (bit_valid) begin
      acc_next[pos_reg] = bit_data;
      pos_next          = pos_reg + 3'h1;
      if (pos_reg == 3'h7) begin
        bv_next  = 1'b1;
        bd_next  = acc_next;
        acc_next = 8'h00;
      end
    end else if (finish && pos_reg != 3'h0) begin
      bv_next  = 1'b1;
      bd_next  = acc_reg;
      acc_next = 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_reg <= 3'h0;
      acc_reg <= 8'h00;
      bv_reg  <= 1'b0;
      bd_reg  <= 8'h00;
    end else begin
      pos_reg <= pos_next;
      acc_reg <= acc_next;
      bv_reg  <= bv_next;
      bd_reg  <= bd_next;
    end
  end

  assign byte_valid = bv_reg;
  assign byte_data  = bd_reg;
  // Bits filled in the final byte; zero means the byte was complete.
  assign tail_bits  = pos_reg;

endmodule

/* core/rbc_core.sv */
`timescale 1ns/1ps
// How it works
// - Without keep control, bits after collision zeroed
// - Alignment field sets first stored bit position
// - Alignment seven: next bit starts following byte
// - Zero alignment is byte-oriented, else bit-oriented
// - Optionally a collision raises integrity error
// - Last-byte count gives valid bits; zero full
// - Count written at end of bit-oriented frames only, cleared at start
// - Valid bit only for reportable first collision
// - Position is index of first collided bit
// - Only first sixty-four bit positions reportable
// - Alignment offset is included in position
// - Collision sets flag and records first position
// - Integrity error flagged, reception continues
module rbc_core (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Receive decoder
  input  wire logic        rx_start,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_coll,
  input  wire logic        rx_integ_err,
  input  wire logic        rx_end,
  // Receive FIFO side
  output logic             fifo_wr_valid,
  output logic [7:0]       fifo_wr_data,
  // Status and interrupt
  output logic             data_integrity_error_flag,
  output logic             collision_detected_flag,
  output logic             bit_oriented,
  output logic             irq
);

  // ==========================================================
  // Helpers.
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    reg_index = a[9:2];
  endfunction

  function automatic logic [31:0] widen(input logic [7:0] v);
    widen = {24'h000000, v};
  endfunction

  // ==========================================================
  // Bus capture.
  logic       wr_pend_reg, wr_pend_next;
  logic [7:0] wr_idx_reg,  wr_idx_next;
  logic [31:0] rdata_reg,  rdata_next;
  logic       addr_take;

  // ==========================================================
  // Registers.
  localparam int unsigned EV_W_L = rbc_pkg::EV_W - 1;

  logic [7:0]      ctrl_reg,   ctrl_next;
  logic [7:0]      cpos_reg,   cpos_next;
  logic            integ_reg,  integ_next;
  logic            coll_reg,   coll_next;
  logic [EV_W_L:0] stat_reg,   stat_next;
  logic [EV_W_L:0] mask_reg,   mask_next;

  // ==========================================================
  // Receive tracking.
  rbc_pkg::rbc_rx_state_t st_reg, st_next;
  logic [7:0] idx_reg,   idx_next;
  logic       seen_reg,  seen_next;
  logic       bit_take;
  logic       bit_store;
  logic       rx_finish;
  logic [2:0] align;
  logic       keep_after;
  logic       no_coll;
  logic [2:0] tail_bits;
  logic [EV_W_L:0] ev;
  logic [EV_W_L:0] w1c;

  assign align      = ctrl_reg[rbc_pkg::BC_ALIGN_LSB +: 3];
  assign keep_after = ctrl_reg[rbc_pkg::BC_KEEP_BIT];
  assign no_coll    = ctrl_reg[rbc_pkg::BC_COLLISION_AS_INTEGRITY_ERROR_BIT];
  assign bit_take   = (st_reg == rbc_pkg::RBC_RECV) && rx_bit_valid;
  assign rx_finish  = (st_reg == rbc_pkg::RBC_RECV) && rx_end;

  // Zero replacement covers bits after the first collided one only.
  assign bit_store = rx_bit & (keep_after | ~seen_reg);

  // ==========================================================
  // Receive state.
  always_comb begin
    st_next   = st_reg;
    idx_next  = idx_reg;
    seen_next = seen_reg;
    case (st_reg)
      rbc_pkg::RBC_IDLE: begin
        if (rx_start) begin
          st_next = rbc_pkg::RBC_RECV;
        end
      end
      rbc_pkg::RBC_RECV: begin
        if (rx_end) begin
          st_next = rbc_pkg::RBC_IDLE;
        end
      end
      default: begin
        st_next = rbc_pkg::RBC_IDLE;
      end
    endcase
    if (rx_start) begin
      idx_next  = {5'h00, align};
      seen_next = 1'b0;
    end else if (bit_take) begin
      if (idx_reg != rbc_pkg::IDX_SAT) begin
        idx_next = idx_reg + 8'h01;
      end
      if (rx_bit_coll) begin
        seen_next = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg   <= rbc_pkg::RBC_IDLE;
      idx_reg  <= 8'h00;
      seen_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      idx_reg  <= idx_next;
      seen_reg <= seen_next;
    end
  end

  // ==========================================================
  // Byte packing.
  rbc_bit_packer u_packer (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .start      (rx_start),
    .finish     (rx_finish),
    .align      (align),
    .bit_valid  (bit_take),
    .bit_data   (bit_store),
    .byte_valid (fifo_wr_valid),
    .byte_data  (fifo_wr_data),
    .tail_bits  (tail_bits)
  );

  // ==========================================================
  // Events.
  always_comb begin
    ev = rbc_pkg::EV_RST;
    ev[rbc_pkg::EV_INTEG] = rx_integ_err | (bit_take & rx_bit_coll & no_coll);
    ev[rbc_pkg::EV_COLL]  = bit_take & rx_bit_coll;
    ev[rbc_pkg::EV_DONE]  = rx_finish;
  end

  // ==========================================================
  // Bus slave. Zero wait states; reads are captured in the address phase.
  assign addr_take = hsel && hready && (htrans == rbc_pkg::HTRANS_NONSEQ);

  always_comb begin
    wr_pend_next = 1'b0;
    wr_idx_next  = wr_idx_reg;
    rdata_next   = rdata_reg;
    if (addr_take) begin
      wr_pend_next = hwrite;
      wr_idx_next  = reg_index(haddr);
      if (!hwrite) begin
        case (reg_index(haddr))
          rbc_pkg::IDX_BIT_CTRL: rdata_next = widen(ctrl_reg);
          rbc_pkg::IDX_COLL_POS: rdata_next = widen(cpos_reg);
          rbc_pkg::IDX_ERR:      rdata_next = {30'h00000000, coll_reg, integ_reg};
          rbc_pkg::IDX_IRQ_STAT: rdata_next = {29'h00000000, stat_reg};
          rbc_pkg::IDX_IRQ_MASK: rdata_next = {29'h00000000, mask_reg};
          default:               rdata_next = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      rdata_reg   <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg  <= wr_idx_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = rbc_pkg::HRESP_OKAY;
  assign hrdata    = rdata_reg;

  // ==========================================================
  // Register updates.
  always_comb begin
    ctrl_next  = ctrl_reg;
    cpos_next  = cpos_reg;
    integ_next = integ_reg;
    coll_next  = coll_reg;
    mask_next  = mask_reg;
    w1c        = rbc_pkg::EV_RST;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        rbc_pkg::IDX_BIT_CTRL: ctrl_next = hwdata[7:0];
        rbc_pkg::IDX_IRQ_STAT: w1c       = hwdata[EV_W_L:0];
        rbc_pkg::IDX_IRQ_MASK: mask_next = hwdata[EV_W_L:0];
        default:               ctrl_next = ctrl_reg;
      endcase
    end
    // Hardware beats a software write in the same cycle.
    if (rx_start) begin
      ctrl_next[rbc_pkg::BC_LAST_LSB +: 3] = 3'h0;
      cpos_next  = rbc_pkg::COLL_POS_RST;
      integ_next = 1'b0;
      coll_next  = 1'b0;
    end else begin
      if (rx_finish && bit_oriented) begin
        ctrl_next[rbc_pkg::BC_LAST_LSB +: 3] = tail_bits;
      end
      if (ev[rbc_pkg::EV_INTEG]) begin
        integ_next = 1'b1;
      end
      if (ev[rbc_pkg::EV_COLL]) begin
        coll_next = 1'b1;
      end
      if (ev[rbc_pkg::EV_COLL] && !seen_reg) begin
        if (idx_reg < rbc_pkg::COLL_LIMIT) begin
          cpos_next = {1'b1, idx_reg[6:0]};
        end else begin
          cpos_next = rbc_pkg::COLL_POS_RST;
        end
      end
    end
    // Sticky events survive a clear in the same cycle.
    stat_next = (stat_reg & ~w1c) | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg  <= rbc_pkg::BIT_CTRL_RST;
      cpos_reg  <= rbc_pkg::COLL_POS_RST;
      integ_reg <= 1'b0;
      coll_reg  <= 1'b0;
      stat_reg  <= rbc_pkg::EV_RST;
      mask_reg  <= rbc_pkg::EV_RST;
    end else begin
      ctrl_reg  <= ctrl_next;
      cpos_reg  <= cpos_next;
      integ_reg <= integ_next;
      coll_reg  <= coll_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
    end
  end

  // ==========================================================
  // Outputs.
  assign bit_oriented              = (align != 3'h0);
  assign data_integrity_error_flag = integ_reg;
  assign collision_detected_flag   = coll_reg;
  assign irq                       = |(stat_reg & mask_reg);

endmodule

/* testbench/rbc_core_sva.sv */
`timescale 1ns/1ps
// ========================================
// Receive framing checker.
module rbc_core_sva (
  input wire logic        hclk, hresetn, hsel, hwrite, hready,
  input wire logic        rx_start, rx_bit_valid, rx_bit_coll, rx_integ_err, rx_end,
  input wire logic        fifo_wr_valid, bit_oriented,
  input wire logic        collision_detected_flag, data_integrity_error_flag,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] hwdata
);
  logic       recv, wq, cb, ies;
  logic [4:0] sh;
  // A shadow of control bits 7:3 stands in for the register the ports hide.
  assign cb = recv && rx_bit_valid && rx_bit_coll && !rx_start;
  assign ies = rx_integ_err || (rx_bit_valid && rx_bit_coll && sh[0]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      recv <= 1'b0;
      wq <= 1'b0;
      sh <= 5'h00;
    end else begin
      recv <= rx_start || (recv && !rx_end);
      wq <= hsel && hready && hwrite && htrans == rbc_pkg::HTRANS_NONSEQ
            && haddr == {2'b00, rbc_pkg::IDX_BIT_CTRL, 2'b00};
      if (wq) begin
        sh <= hwdata[7:3];
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_coll; cb |=> collision_detected_flag; endproperty
  a_coll: assert property (p_coll) else $error("collision flag missing");
  property p_hold; collision_detected_flag && !rx_start |=> collision_detected_flag; endproperty
  a_hold: assert property (p_hold) else $error("collision flag lost");
  property p_integ; recv && rx_integ_err && !rx_start |=> data_integrity_error_flag; endproperty
  a_integ: assert property (p_integ) else $error("integrity flag missing");
  property p_ncoll; cb && sh[0] |=> data_integrity_error_flag; endproperty
  a_ncoll: assert property (p_ncoll) else $error("collision not integrity");
  property p_cause; $rose(data_integrity_error_flag) |-> $past(ies); endproperty
  a_cause: assert property (p_cause) else $error("integrity flag unprompted");
  property p_clr;
    rx_start && !rx_bit_valid && !rx_integ_err |=>
      !collision_detected_flag && !data_integrity_error_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_mode; bit_oriented == (sh[3:1] != 3'h0); endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_pulse; fifo_wr_valid |=> !fifo_wr_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("bytes too close");
  property p_inrx; fifo_wr_valid |-> $past(recv); endproperty
  a_inrx: assert property (p_inrx) else $error("byte outside frame");
  c_coll: cover property (cb ##1 collision_detected_flag);
  c_byte: cover property (fifo_wr_valid && bit_oriented);
  c_int: cover property ($rose(data_integrity_error_flag));
endmodule

bind rbc_core rbc_core_sva i_sva (.*);

/* testbench/rbc_dec_model.sv */
`timescale 1ns/1ps
// ========================================
// Decoder stand-in; a slow frame leaves an idle cycle before every odd bit.
module rbc_dec_model (
  input wire logic hclk,
  output logic     rx_start, rx_bit_valid, rx_bit, rx_bit_coll, rx_integ_err, rx_end
);
  initial begin
    {rx_start, rx_bit_valid, rx_bit, rx_bit_coll, rx_integ_err, rx_end} = 6'h00;
  end
  task automatic frame(input int n, input logic [71:0] d, input int c, input bit ie,
                       input bit slow);
    @(posedge hclk);
    rx_start <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      rx_start <= 1'b0;
      if (slow && i[0]) begin
        rx_bit_valid <= 1'b0;
        rx_bit <= ~rx_bit;
        @(posedge hclk);
      end
      rx_bit_valid <= 1'b1;
      rx_bit <= d[i];
      rx_bit_coll <= c >= 0 && (i == c || i == c + 2);
      rx_integ_err <= ie && i == n / 2;
    end
    @(posedge hclk);
    rx_bit_valid <= 1'b0;
    rx_bit_coll <= 1'b0;
    rx_integ_err <= 1'b0;
    rx_bit <= ~d[n-1];
    rx_end <= 1'b1;
    @(posedge hclk);
    rx_end <= 1'b0;
  endtask
endmodule

/* testbench/rbc_core_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
// ========================================
// Bench for the receive framing block.
module rbc_core_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic        hready, hreadyout, hresp, fifo_wr_valid, irq, bit_oriented;
  logic        rx_start, rx_bit_valid, rx_bit, rx_bit_coll, rx_integ_err, rx_end;
  logic        data_integrity_error_flag, collision_detected_flag;
  logic [7:0]  fifo_wr_data;
  logic [7:0]  exp_q[$];
  int          err_total = 0, num_checks = 0, cyc = 0;
  integer      seed = 32'h2e459b9c;
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  rbc_core i_dut (.*);
  rbc_dec_model i_dec (.*);
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // The master never assumes zero wait states; the timeout ends any hang.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= rbc_pkg::HTRANS_NONSEQ;
    haddr <= {2'b00, idx, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 32'h0);
    `CHK(nm, {24'h0, e}, rd)
    `CHK("hresp", rbc_pkg::HRESP_OKAY, hresp)
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
    if (fifo_wr_valid === 1'b1) begin
      `CHK("fifo byte", exp_q[0], fifo_wr_data)
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  initial begin : main
    int a, n, c, pos, lb;
    bit k, nc, ie;
    logic [95:0] d;
    logic [7:0] b[10];
    logic [2:0] m, st;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("ctrl rst", rbc_pkg::IDX_BIT_CTRL, rbc_pkg::BIT_CTRL_RST);
    rchk("unmapped", 8'h30, 8'h00);
    bus(1'b1, rbc_pkg::IDX_COLL_POS, 32'hFF);
    rchk("coll ro", rbc_pkg::IDX_COLL_POS, rbc_pkg::COLL_POS_RST);
    for (int t = 0; t < 24; t++) begin
      d = {$random(seed), $random(seed), $random(seed)};
      a = t % 8;
      {k, nc, m} = d[95:91];
      ie = t % 5 == 3;
      n = t % 8 == 7 ? 72 : 1 + $unsigned($random(seed)) % 72;
      c = t % 3 == 0 ? -1 : $unsigned($random(seed)) % n;
      if (t % 8 == 7) c = 56 + t / 8;
      for (int j = 0; j < 10; j++) b[j] = 8'h00;
      for (int i = 0; i < n; i++) begin
        pos = a + i;
        b[pos/8][pos%8] = c >= 0 && i > c && !k ? 1'b0 : d[i];
      end
      for (int j = 0; j < (a + n + 7) / 8; j++) exp_q.push_back(b[j]);
      bus(1'b1, rbc_pkg::IDX_BIT_CTRL, {24'h0, k, a[2:0], nc, 3'h0});
      bus(1'b1, rbc_pkg::IDX_IRQ_MASK, {29'h0, m});
      `CHK("mode", a != 0, bit_oriented)
      i_dec.frame(n, d[71:0], c, ie, t[1]);
      repeat (3) @(posedge hclk);
      `CHK("fifo left", 0, exp_q.size())
      pos = a + c;
      lb = a != 0 ? (a + n) % 8 : 0;
      st = {1'b1, c >= 0, ie || (nc && c >= 0)};
      rchk("coll", rbc_pkg::IDX_COLL_POS, c >= 0 && pos < 64 ? {1'b1, pos[6:0]} : 8'h00);
      rchk("ctrl", rbc_pkg::IDX_BIT_CTRL, {k, a[2:0], nc, lb[2:0]});
      rchk("err", rbc_pkg::IDX_ERR, {6'h0, st[1:0]});
      rchk("stat", rbc_pkg::IDX_IRQ_STAT, {5'h0, st});
      `CHK("irq", |(st & m), irq)
      bus(1'b1, rbc_pkg::IDX_IRQ_STAT, 32'h7);
      rchk("stat clr", rbc_pkg::IDX_IRQ_STAT, 8'h00);
      `CHK("irq clr", 1'b0, irq)
    end
    give_verdict();
  end
endmodule
